// ==== common/drive_setpoint_consts.vh ====
// constants for the setpoint and current-control block
`ifndef DRIVE_SETPOINT_CONSTS_VH
`define DRIVE_SETPOINT_CONSTS_VH

// register byte offsets
`define DSC_REG_SUBMODE 8'h00
`define DSC_REG_MAX_CUR 8'h04
`define DSC_REG_IDLE_MS 8'h08
`define DSC_REG_RED_CUR 8'h0C
`define DSC_REG_POLES 8'h10
`define DSC_REG_CONTROL 8'h14
`define DSC_REG_OPREQ 8'h18
`define DSC_REG_STATUS 8'h1C
`define DSC_REG_TVEL 8'h20
`define DSC_REG_CURRENT 8'h24
`define DSC_REG_SCALE 8'h28

// submode and control field positions
`define DSC_SUB_LOOP 0
`define DSC_SUB_REDUCE 3
`define DSC_SUB_BLDC 4
`define DSC_SUB_ENCODER 5
`define DSC_SUB_HYBRID 6
`define DSC_SUB_DIP_EN 7
`define DSC_CTL_PWR 0
`define DSC_CTL_RESTART 8

// reset values
`define DSC_SUBMODE_RST 8'h80
`define DSC_MAX_CUR_RST 16'h03E8
`define DSC_IDLE_MS_RST 16'h03E8
`define DSC_RED_CUR_RST 16'h01F4
`define DSC_POLES_RST 16'h0032

// operating mode codes
`define DSC_OM_NONE 8'h00
`define DSC_OM_PP 8'h01
`define DSC_OM_VEL 8'h03
`define DSC_OM_PV 8'h02
`define DSC_OM_PT 8'h04
`define DSC_OM_HOME 8'h06
`define DSC_OM_IP 8'h07
`define DSC_OM_CSP 8'h08
`define DSC_OM_CSV 8'h09
`define DSC_OM_CST 8'h0A
`define DSC_OM_CLKDIR 8'hFF

// speeds in rpm, currents in tenths of a percent
`define DSC_RPM_HI 11'h03E8
`define DSC_RPM_LO 11'h0064
`define DSC_RPM_TEST 16'h001E
`define DSC_CUR_LIMIT 16'h03E8

// analog front end: 12-bit code over 0..10000 mV
`define DSC_ADC_FS_MV 10000
`define DSC_DEADZONE_MV 20
`define DSC_ADC_MID 12'h800

// timing
`define DSC_CLK_NS 8
`define DSC_MS_NS 1000000

`endif

// ==== core/analog_speed_map.v ====
// maps the analog input code to a signed speed in rpm
`timescale 1ns/10ps
`include "drive_setpoint_consts.vh"

module analog_speed_map #(
  parameter integer ADC_BITS = 12
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [ADC_BITS-1:0] i_adc_code,
  input wire i_joystick,
  input wire i_max_lo,
  input wire i_dir_ccw,
  output reg signed [15:0] o_speed_rpm
);
  // 20 mV in codes, rounded down so the dead zone never grows past 20 mV
  localparam integer DZ_CODES = (`DSC_DEADZONE_MV * ((1 << ADC_BITS) - 1)) / `DSC_ADC_FS_MV;
  localparam [ADC_BITS-1:0] DZ = DZ_CODES[ADC_BITS-1:0];
  localparam [ADC_BITS-1:0] MID = `DSC_ADC_MID;

  wire [10:0] max_rpm = i_max_lo ? `DSC_RPM_LO : `DSC_RPM_HI;
  wire above_mid = (i_adc_code >= MID);
  wire [ADC_BITS-1:0] dev = above_mid ? (i_adc_code - MID) : (MID - i_adc_code);
  wire [ADC_BITS+10:0] prod_n = i_adc_code * max_rpm;
  wire [ADC_BITS+10:0] prod_j = dev * max_rpm;
  // full code maps to max speed; shift approximates the divide by full scale
  wire [15:0] mag_n = {5'h00, prod_n[ADC_BITS+10:ADC_BITS]};
  wire [15:0] mag_j = {5'h00, prod_j[ADC_BITS+9:ADC_BITS-1]};
  reg signed [15:0] spd_d;

  always @* begin
    spd_d = 16'sh0000;
    if (i_joystick) begin
      if (dev > DZ) begin
        spd_d = above_mid ? $signed(mag_j) : -$signed(mag_j);
      end
    end else if (i_adc_code > DZ) begin
      // no direction signal means positive, i.e. clockwise
      spd_d = i_dir_ccw ? -$signed(mag_n) : $signed(mag_n);
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_speed_rpm <= 16'sh0000;
    end else begin
      o_speed_rpm <= spd_d;
    end
  end
endmodule

// ==== core/drive_setpoint_ctrl.v ====
// setpoint, special drive modes and open-loop current control with axi4-lite registers
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "drive_setpoint_consts.vh"

module drive_setpoint_ctrl #(
  parameter integer ADC_BITS = 12,
  parameter integer MS_CYCLES = `DSC_MS_NS / `DSC_CLK_NS
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire [7:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [7:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  input wire [3:0] i_mode_sw,
  input wire i_enable_in,
  input wire i_dir_in,
  input wire [ADC_BITS-1:0] i_adc_code,
  output reg [7:0] o_op_mode,
  output reg signed [15:0] o_target_vel,
  output reg [15:0] o_cur_setpoint,
  output reg o_power_enable,
  output reg o_cur_reduced,
  output reg o_loop_closed,
  output reg o_hybrid_active,
  output reg o_special_active
);
  // byte-lane merge used by the submode, max current, idle, reduced current and poles registers
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer k;
    begin
      merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `DSC_REG_SCALE);
    end
  endfunction

  localparam [31:0] MS_LAST = MS_CYCLES - 1;

  // configuration written by software; power, mode request and homing method act at once, the rest waits for a restart
  reg [7:0] sub_q;
  reg [15:0] max_cur_q;
  reg [15:0] idle_ms_q;
  reg [15:0] red_cur_q;
  reg [15:0] poles_q;
  reg ctl_pwr_q;
  reg [7:0] opreq_q;
  reg [7:0] home_meth_q;
  // configuration in force since the last restart
  reg [7:0] act_sub_q;
  reg [15:0] act_max_cur_q;
  reg [15:0] act_idle_ms_q;
  reg [15:0] act_red_cur_q;
  reg [15:0] act_poles_q;
  reg [3:0] act_sw_q;
  reg restart_q;

  // axi write path state
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  reg [31:0] ms_cnt_q;
  reg [15:0] idle_cnt_q;
  reg refused_q;

  assign o_s_axi_awready = ~aw_full_q & ~o_s_axi_bvalid;
  assign o_s_axi_wready = ~w_full_q & ~o_s_axi_bvalid;
  assign o_s_axi_arready = ~o_s_axi_rvalid;
  wire wr_go = aw_full_q & w_full_q & ~o_s_axi_bvalid;
  wire restart_wr = wr_go && (aw_addr_q == `DSC_REG_CONTROL) && w_strb_q[1] &&
    w_data_q[`DSC_CTL_RESTART];
  reg [31:0] wr_old;

  always @* begin
    case (aw_addr_q)
      `DSC_REG_SUBMODE: wr_old = {24'h0, sub_q};
      `DSC_REG_MAX_CUR: wr_old = {16'h0, max_cur_q};
      `DSC_REG_IDLE_MS: wr_old = {16'h0, idle_ms_q};
      `DSC_REG_RED_CUR: wr_old = {16'h0, red_cur_q};
      `DSC_REG_POLES: wr_old = {16'h0, poles_q};
      default: wr_old = 32'h0000_0000;
    endcase
  end

  wire [31:0] wr_new = merge(wr_old, w_data_q, w_strb_q);

  // effective configuration, derived from the active copy only
  wire dip_en = act_sub_q[`DSC_SUB_DIP_EN];
  wire is_bldc = act_sub_q[`DSC_SUB_BLDC];
  wire loop_cfg = dip_en ? act_sw_q[3] : act_sub_q[`DSC_SUB_LOOP];
  wire loop_closed = loop_cfg | is_bldc;
  wire hybrid_ok = act_sub_q[`DSC_SUB_HYBRID] & act_sub_q[`DSC_SUB_ENCODER];
  wire red_en = act_sub_q[`DSC_SUB_REDUCE] & ~loop_closed;
  wire mode_analog = dip_en & act_sw_q[0];
  wire mode_test = dip_en & ~act_sw_q[0] & act_sw_q[1];
  wire mode_joy = mode_analog & act_sw_q[1];
  wire [10:0] max_rpm = act_sw_q[2] ? `DSC_RPM_LO : `DSC_RPM_HI;
  wire [11:0] ana_offset = mode_joy ? `DSC_ADC_MID : 12'h000;

  wire signed [15:0] ana_speed;

  analog_speed_map #(
    .ADC_BITS(ADC_BITS)
  ) u_map (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_adc_code(i_adc_code),
    .i_joystick(mode_joy),
    .i_max_lo(act_sw_q[2]),
    .i_dir_ccw(i_dir_in),
    .o_speed_rpm(ana_speed)
  );

  // operating mode admission
  wire req_torque = (opreq_q == `DSC_OM_PT) || (opreq_q == `DSC_OM_CST);
  // negative methods -1..-4 are the on-block searches
  wire home_block = home_meth_q[7] && (home_meth_q >= 8'hFC);
  wire req_home_blk = (opreq_q == `DSC_OM_HOME) && home_block;
  wire req_refused = ~loop_closed & (req_torque | req_home_blk);
  reg [7:0] op_mode_d;
  reg pwr_d;
  reg signed [15:0] vel_d;

  always @* begin
    op_mode_d = o_op_mode;
    pwr_d = ctl_pwr_q;
    vel_d = 16'sh0000;
    if (dip_en) begin
      pwr_d = i_enable_in;
      if (mode_analog) begin
        op_mode_d = `DSC_OM_VEL;
        vel_d = ana_speed;
      end else begin
        op_mode_d = `DSC_OM_CLKDIR;
        if (mode_test) begin
          vel_d = act_sw_q[2] ? -$signed(`DSC_RPM_TEST) : $signed(`DSC_RPM_TEST);
        end
      end
    end else if (!req_refused) begin
      op_mode_d = opreq_q;
    end else if (o_op_mode == opreq_q) begin
      // a restart into open loop must not leave a refused mode running
      op_mode_d = `DSC_OM_NONE;
    end
    if (!pwr_d) begin
      vel_d = 16'sh0000;
    end
  end

  // current: clamp, then reduce at standstill in open loop only
  wire [15:0] cur_full = (act_max_cur_q > `DSC_CUR_LIMIT) ? `DSC_CUR_LIMIT : act_max_cur_q;
  wire [15:0] cur_red = (act_red_cur_q < cur_full) ? act_red_cur_q : cur_full;
  wire standstill = (vel_d == 16'sh0000);
  wire ms_tick = (ms_cnt_q == MS_LAST);
  wire idle_done = (idle_cnt_q >= act_idle_ms_q);
  wire reduce_now = red_en & standstill & idle_done;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ms_cnt_q <= 32'h0000_0000;
      idle_cnt_q <= 16'h0000;
      o_op_mode <= `DSC_OM_NONE;
      o_target_vel <= 16'sh0000;
      o_cur_setpoint <= 16'h0000;
      o_power_enable <= 1'b0;
      o_cur_reduced <= 1'b0;
      o_loop_closed <= 1'b0;
      o_hybrid_active <= 1'b0;
      o_special_active <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      // idle time is counted on the commanded value, not on feedback
      if (!standstill) begin
        idle_cnt_q <= 16'h0000;
      end else if (ms_tick && !idle_done) begin
        idle_cnt_q <= idle_cnt_q + 16'h0001;
      end
      o_op_mode <= op_mode_d;
      o_target_vel <= vel_d;
      o_power_enable <= pwr_d;
      // open loop runs full current while moving, reduced current after the idle time at standstill; no feedback is consulted
      o_cur_setpoint <= pwr_d ? (reduce_now ? cur_red : cur_full) : 16'h0000;
      o_cur_reduced <= pwr_d & reduce_now;
      o_loop_closed <= loop_closed;
      o_hybrid_active <= hybrid_ok & loop_closed;
      o_special_active <= dip_en;
      refused_q <= ~dip_en & req_refused;
    end
  end

  // restart: pending copy and switch positions become active here only
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      restart_q <= 1'b1;
      act_sub_q <= `DSC_SUBMODE_RST;
      act_max_cur_q <= `DSC_MAX_CUR_RST;
      act_idle_ms_q <= `DSC_IDLE_MS_RST;
      act_red_cur_q <= `DSC_RED_CUR_RST;
      act_poles_q <= `DSC_POLES_RST;
      act_sw_q <= 4'h0;
    end else begin
      restart_q <= restart_wr;
      if (restart_q) begin
        act_sub_q <= sub_q;
        act_max_cur_q <= max_cur_q;
        act_idle_ms_q <= idle_ms_q;
        act_red_cur_q <= red_cur_q;
        act_poles_q <= poles_q;
        act_sw_q <= i_mode_sw;
      end
    end
  end

  // axi4-lite write channel
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= 2'b00;
      sub_q <= `DSC_SUBMODE_RST;
      max_cur_q <= `DSC_MAX_CUR_RST;
      idle_ms_q <= `DSC_IDLE_MS_RST;
      red_cur_q <= `DSC_RED_CUR_RST;
      poles_q <= `DSC_POLES_RST;
      ctl_pwr_q <= 1'b0;
      opreq_q <= `DSC_OM_NONE;
      home_meth_q <= 8'h00;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= mapped(aw_addr_q) ? 2'b00 : 2'b10;
        case (aw_addr_q)
          `DSC_REG_SUBMODE: sub_q <= wr_new[7:0];
          `DSC_REG_MAX_CUR: max_cur_q <= wr_new[15:0];
          `DSC_REG_IDLE_MS: idle_ms_q <= wr_new[15:0];
          `DSC_REG_RED_CUR: red_cur_q <= wr_new[15:0];
          `DSC_REG_POLES: poles_q <= wr_new[15:0];
          `DSC_REG_CONTROL: begin
            if (w_strb_q[0]) begin
              ctl_pwr_q <= w_data_q[`DSC_CTL_PWR];
            end
          end
          `DSC_REG_OPREQ: begin
            if (w_strb_q[0]) begin
              opreq_q <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
              home_meth_q <= w_data_q[15:8];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // axi4-lite read channel
  reg [31:0] rd_d;

  always @* begin
    case (i_s_axi_araddr)
      `DSC_REG_SUBMODE: rd_d = {24'h0, sub_q};
      `DSC_REG_MAX_CUR: rd_d = {16'h0, max_cur_q};
      `DSC_REG_IDLE_MS: rd_d = {16'h0, idle_ms_q};
      `DSC_REG_RED_CUR: rd_d = {16'h0, red_cur_q};
      `DSC_REG_POLES: rd_d = {16'h0, poles_q};
      `DSC_REG_CONTROL: rd_d = {31'h0, ctl_pwr_q};
      `DSC_REG_OPREQ: rd_d = {16'h0, home_meth_q, opreq_q};
      `DSC_REG_STATUS: rd_d = {8'h0, act_sub_q, o_op_mode, 1'b0, refused_q, o_special_active,
        o_hybrid_active, o_loop_closed, o_cur_reduced, o_power_enable, red_en};
      `DSC_REG_TVEL: rd_d = {{16{o_target_vel[15]}}, o_target_vel};
      `DSC_REG_CURRENT: rd_d = {act_poles_q, o_cur_setpoint};
      `DSC_REG_SCALE: rd_d = {4'h0, ana_offset, 5'h00, max_rpm};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= 2'b00;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_d;
      o_s_axi_rresp <= mapped(i_s_axi_araddr) ? 2'b00 : 2'b10;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== dv/drive_setpoint_asserts.sv ====
// concurrent checks on the setpoint and current-control ports
`timescale 1ns/10ps
`include "drive_setpoint_consts.vh"
module drive_setpoint_asserts #(
  parameter integer MS_CYCLES = 125000
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_enable_in,
  input wire [7:0] o_op_mode,
  input wire signed [15:0] o_target_vel,
  input wire [15:0] o_cur_setpoint,
  input wire o_power_enable,
  input wire o_cur_reduced,
  input wire o_loop_closed,
  input wire o_hybrid_active,
  input wire o_special_active
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [31:0] still_q;
  wire [31:0] still_d = (o_target_vel != 0) ? 32'h0000_0000 : still_q + 32'h0000_0001;
  always @(posedge i_clk) begin
    still_q <= i_sys_rst ? 32'h0000_0000 : still_d;
  end
  sequence en_held_s; (o_special_active && i_enable_in) [*4]; endsequence
  sequence en_low_s; (o_special_active && !i_enable_in) [*4]; endsequence
  sequence power_off_s; !o_power_enable [*3]; endsequence
  pwr_follow_en_a:
    assert property (en_held_s |-> o_power_enable) else $error("power not following enable");
  pwr_drop_en_a:
    assert property (en_low_s |-> !o_power_enable) else $error("power on without enable");
  vel_when_off_a:
    assert property (power_off_s |-> o_target_vel == 0) else $error("motion while off");
  cur_when_off_a:
    assert property (power_off_s |-> o_cur_setpoint == 0) else $error("current while off");
  cur_clamp_a:
    assert property (o_cur_setpoint <= `DSC_CUR_LIMIT) else $error("current above limit");
  reduce_delay_a:
    assert property ($rose(o_cur_reduced) |-> still_q >= MS_CYCLES)
    else $error("reduction before idle time");
  reduce_open_a:
    assert property (o_cur_reduced |-> !o_loop_closed) else $error("reduction in closed loop");
  torque_refused_a:
    assert property (!o_loop_closed && $stable(o_loop_closed) |->
      o_op_mode != `DSC_OM_PT && o_op_mode != `DSC_OM_CST) else $error("torque mode open loop");
  hybrid_closed_a:
    assert property (o_hybrid_active && $stable(o_loop_closed) |-> o_loop_closed)
    else $error("hybrid without closed loop");
endmodule
bind drive_setpoint_ctrl drive_setpoint_asserts #(.MS_CYCLES(MS_CYCLES)) asserts_inst (.*);

// ==== dv/motor_io_model.sv ====
// far-side stand-in: switches, enable, direction and analog lines plus a shaft
`timescale 1ns/10ps
module motor_io_model (
  input wire i_clk,
  input wire [3:0] i_sw_set,
  input wire i_en_set,
  input wire i_dir_set,
  input wire [11:0] i_adc_set,
  input wire i_power,
  input wire signed [15:0] i_vel,
  output logic [3:0] o_mode_sw,
  output logic o_enable,
  output logic o_dir,
  output logic [11:0] o_adc,
  output logic signed [31:0] o_shaft
);
  initial begin
    {o_mode_sw, o_enable, o_dir, o_adc} = '0;
    o_shaft = '0;
  end
  // lines are levels, so one register stage stands in for the wiring
  always @(posedge i_clk) begin
    o_mode_sw <= i_sw_set;
    o_enable <= i_en_set;
    o_dir <= i_dir_set;
    o_adc <= i_adc_set;
    if (i_power) begin
      o_shaft <= o_shaft + i_vel;
    end
  end
endmodule

// ==== dv/test_drive_setpoint_ctrl.sv ====
// random and corner-case bench for the setpoint and current-control block
`timescale 1ns/10ps
`include "drive_setpoint_consts.vh"
module test_drive_setpoint_ctrl;
  logic i_clk = 0, i_sys_rst = 1;
  logic [7:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
  logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  logic i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  logic [31:0] i_s_axi_wdata = 0;
  logic [3:0] i_s_axi_wstrb = 4'hF;
  wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
  wire [31:0] o_s_axi_rdata;
  wire [3:0] i_mode_sw;
  wire i_enable_in, i_dir_in;
  wire [11:0] i_adc_code;
  wire [7:0] o_op_mode;
  wire signed [15:0] o_target_vel;
  wire [15:0] o_cur_setpoint;
  wire o_power_enable, o_cur_reduced, o_loop_closed, o_hybrid_active, o_special_active;
  logic [3:0] sw = 0, s;
  logic en = 0, dir = 0;
  logic [11:0] adc = 0, c;
  logic [31:0] rng = 32'h0001_3CC3, rd, r;
  logic [1:0] rr;
  logic [11:0] cn [8] = '{12'h000, 12'h008, 12'h009, 12'h7F7, 12'h7F8, 12'h808, 12'h809,
    12'hFFF};
  int fails = 0, cmp_count = 0, cyc = 0;
  drive_setpoint_ctrl #(.MS_CYCLES(10)) drive_setpoint_ctrl_inst (.*);
  motor_io_model motor_io_model_inst (.i_clk(i_clk), .i_sw_set(sw), .i_en_set(en),
    .i_dir_set(dir), .i_adc_set(adc), .i_power(o_power_enable), .i_vel(o_target_vel),
    .o_mode_sw(i_mode_sw), .o_enable(i_enable_in), .o_dir(i_dir_in), .o_adc(i_adc_code),
    .o_shaft());
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      complete_run();
    end
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // expected speed; the dead zone is 8 codes on a 10 V scale
  function automatic logic signed [15:0] vexp(input logic [3:0] w, input logic e, d,
      input logic [11:0] a);
    int m, v;
    m = w[2] ? `DSC_RPM_LO : `DSC_RPM_HI;
    v = int'(a) - 2048;
    if (!e) return 0;
    if (!w[0]) return w[1] ? (w[2] ? -`DSC_RPM_TEST : `DSC_RPM_TEST) : 0;
    if (w[1]) return (v <= 8 && v >= -8) ? 0 : (v < 0 ? -((-v * m) >> 11) : (v * m) >> 11);
    return a <= 8 ? 0 : (d ? -((a * m) >> 12) : (a * m) >> 12);
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // trailing edge keeps the next call from driving the same signals in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
    forever begin
      @(posedge i_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 0;
      if (o_s_axi_bvalid) break;
    end
    i_s_axi_bready <= 0;
    @(posedge i_clk);
  endtask
  task automatic rdr(input logic [7:0] a);
    i_s_axi_araddr <= a;
    {i_s_axi_arvalid, i_s_axi_rready} <= 2'h3;
    forever begin
      @(posedge i_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 0;
      if (o_s_axi_rvalid) break;
    end
    rd = o_s_axi_rdata;
    rr = o_s_axi_rresp;
    i_s_axi_rready <= 0;
    @(posedge i_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask
  task automatic boot(input logic [3:0] w);
    sw <= w;
    @(posedge i_clk);
    wr(`DSC_REG_CONTROL, 32'h0000_0100);
    repeat (6) @(posedge i_clk);
  endtask
  task automatic opq(input logic [31:0] q, input logic [7:0] e);
    wr(`DSC_REG_OPREQ, q);
    repeat (3) @(posedge i_clk);
    chk(o_op_mode, e);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 0;
    @(posedge i_clk);
    rchk(`DSC_REG_SUBMODE, 32'h0000_0080);
    rchk(`DSC_REG_MAX_CUR, 32'h0000_03E8);
    rchk(`DSC_REG_IDLE_MS, 32'h0000_03E8);
    rchk(`DSC_REG_RED_CUR, 32'h0000_01F4);
    rchk(`DSC_REG_POLES, 32'h0000_0032);
    rdr(8'h40);
    chk(rr, 2'h2);
    $display("register defaults done");
    en <= 1;
    for (int k = 0; k < 4; k++) begin
      s = {2'h0, k[1:0]} << 1 | 4'h1;
      boot(s);
      chk(o_op_mode, `DSC_OM_VEL);
      rchk(`DSC_REG_SCALE, {4'h0, k[0] ? 12'h800 : 12'h000, 5'h00, k[1] ? 11'h064 : 11'h3E8});
      for (int j = 0; j < 24; j++) begin
        r = xs();
        c = j < 8 ? cn[j] : r[11:0];
        dir <= r[12] & ~s[1];
        adc <= c;
        repeat (5) @(posedge i_clk);
        chk(o_target_vel, vexp(s, 1, dir, c));
      end
    end
    sw <= 4'h2;
    repeat (5) @(posedge i_clk);
    chk(o_op_mode, `DSC_OM_VEL);
    en <= 0;
    wr(`DSC_REG_CONTROL, 32'h0000_0001);
    repeat (5) @(posedge i_clk);
    chk(o_power_enable, 0);
    chk(o_target_vel, 0);
    $display("analog speed done");
    for (int k = 0; k < 2; k++) begin
      en <= 1;
      boot({1'b0, k[0], 2'h2});
      chk(o_target_vel, vexp({1'b0, k[0], 2'h2}, 1, 0, 0));
      en <= 0;
      repeat (5) @(posedge i_clk);
      chk(o_target_vel, 0);
    end
    $display("test run done");
    en <= 1;
    wr(`DSC_REG_MAX_CUR, 32'h0000_05DC);
    wr(`DSC_REG_SUBMODE, 32'h0000_0088);
    wr(`DSC_REG_IDLE_MS, 32'h0000_0002);
    wr(`DSC_REG_RED_CUR, 32'h0000_012C);
    wr(`DSC_REG_POLES, 32'h0000_0064);
    boot(4'h0);
    chk(o_cur_setpoint, 16'h03E8);
    chk(o_loop_closed, 0);
    rchk(`DSC_REG_CURRENT, 32'h0064_03E8);
    for (int n = 0; n < 80 && o_cur_reduced !== 1; n++) @(posedge i_clk);
    chk(o_cur_reduced, 1);
    chk(o_cur_setpoint, 16'h012C);
    wr(`DSC_REG_SUBMODE, 32'h0000_0080);
    boot(4'h0);
    repeat (60) @(posedge i_clk);
    chk(o_cur_reduced, 0);
    chk(o_cur_setpoint, 16'h03E8);
    $display("open loop current done");
    wr(`DSC_REG_SUBMODE, 32'h0000_0000);
    boot(4'h0);
    opq(32'h0000_0004, `DSC_OM_NONE);
    opq(32'h0000_000A, `DSC_OM_NONE);
    opq(32'h0000_FC06, `DSC_OM_NONE);
    opq(32'h0000_0106, `DSC_OM_HOME);
    rchk(`DSC_REG_STATUS, {8'h00, 8'h00, 8'h06, 8'h00});
    wr(`DSC_REG_SUBMODE, 32'h0000_0061);
    boot(4'h0);
    chk(o_loop_closed, 1);
    chk(o_hybrid_active, 1);
    opq(32'h0000_0004, `DSC_OM_PT);
    wr(`DSC_REG_SUBMODE, 32'h0000_0000);
    boot(4'h0);
    chk(o_op_mode, `DSC_OM_NONE);
    wr(`DSC_REG_SUBMODE, 32'h0000_0041);
    boot(4'h0);
    chk(o_hybrid_active, 0);
    wr(`DSC_REG_SUBMODE, 32'h0000_0010);
    boot(4'h0);
    chk(o_loop_closed, 1);
    $display("control modes done");
    complete_run();
  end
endmodule
